//--- verilog/tuerr_pkg.sv
// Package for the translation unit error record: offsets, fields, resets.
// Assumes a 32-bit plain register port with byte offsets.
package tuerr_pkg;

    localparam logic [15:0] OFF_FEATURE = 16'h8e80;
    localparam logic [15:0] OFF_CONTROL = 16'h8e88;
    localparam logic [15:0] OFF_SYNDROME = 16'h8e90;
    localparam logic [15:0] OFF_IRQ_STATUS = 16'h8ea0;
    localparam logic [15:0] OFF_IRQ_MASK = 16'h8ea4;

    localparam logic [31:0] RST_FEATURE = 32'h0000_0081;
    localparam logic [31:0] RST_CONTROL = 32'h0000_0008;
    localparam logic [31:0] RST_SYNDROME = 32'h0000_0000;
    localparam logic [1:0] RST_IRQ_MASK = 2'h3;

    localparam int FEAT_IC_LSB = 6;
    localparam int FEAT_DT_LSB = 0;
    localparam logic [1:0] FEAT_IC_VAL = 2'h2;
    localparam logic [1:0] FEAT_DT_VAL = 2'h1;

    localparam int CTL_IRQ_BIT = 3;

    localparam int SYN_V_BIT = 30;
    localparam int SYN_OVF_BIT = 27;
    localparam int SYN_CE_LSB = 24;
    localparam int SYN_SRC_LSB = 8;
    localparam int SYN_KIND_LSB = 0;
    localparam logic [1:0] CE_CORRECTED = 2'h2;
    localparam logic [1:0] CE_CLEAR_CODE = 2'h3;
    localparam logic [1:0] CE_NONE = 2'h0;
    localparam logic [7:0] KIND_NONE = 8'h00;
    localparam logic [7:0] KIND_TAG = 8'h07;
    localparam logic [7:0] KIND_DATA = 8'h08;
    localparam logic [7:0] SRC_MAX = 8'h08;

    // Sticky event bits: 0 corrected error, 1 overflow
    localparam int EV_CE = 0;
    localparam int EV_OVF = 1;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
        logic secure;
    } tuerr_bus_t;

    typedef struct packed {
        logic valid;
        logic tag_err;
        logic [7:0] source;
    } tuerr_err_t;

    typedef struct packed {
        logic irq_en;
        logic v;
        logic ovf;
        logic [1:0] ce;
        logic [7:0] src;
        logic [7:0] kind;
        logic [1:0] ev_stat;
        logic [1:0] ev_mask;
        logic [31:0] rdata;
    } tuerr_state_t;

endpackage : tuerr_pkg

//--- verilog/tuerr_record.sv
// Error record register bank of the translation control unit.
// Assumes one clock, synchronous reset, and a secure-side access bit
// and error reports from logic on the same clock.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1: The feature register's fault interrupt field always reads 0b10; non-secure reads with access bit 0 get 0 here.
// RULE2: The feature register's detection field always reads 0b01; non-secure reads with access bit 0 get 0 here.
// RULE3: Control bit 3 set lets faults raise the interrupt; clear blocks it.
// RULE4: With access bit 0, non-secure control/syndrome reads give 0, writes drop.
// RULE5: Syndrome bit 30 sets whenever an error has been recorded.
// RULE6: Writing 1 clears bit 30 unless the error field stays nonzero.
// RULE7: Overflow bit 27 sets when an error arrives with the error field set.
// RULE8: Writing 1 clears the overflow bit; writing 0 leaves it.
// RULE9: A corrected error loads the two-bit error field with 0b10.
// RULE10: Writing 0b11 clears the error field unless overflow stays set.
// RULE11: The source field at 15:8 names the cache that saw the error.
// RULE12: Software writes to the source field are ignored.
// RULE13: The kind field keeps the earliest unacknowledged error.
// RULE14: Kind reads 0x00 with no error, 0x07 for tag, 0x08 for data.
// RULE15: The interrupt stays high while enabled and a record is pending.
module tuerr_record (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [15:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic secure_in,
    output logic [31:0] rdata_out,
    // Access control from the secure side
    input wire logic nonsecure_reliability_access_in,
    // Corrected error report
    input wire logic err_valid_in,
    input wire logic err_tag_in,
    input wire logic [7:0] err_source_in,
    // Interrupts
    output logic fault_irq_out,
    output logic event_irq_out
);

    tuerr_pkg::tuerr_state_t st_r;
    tuerr_pkg::tuerr_state_t st_nxt;
    tuerr_pkg::tuerr_bus_t bus;
    tuerr_pkg::tuerr_err_t err;
    logic allowed;
    logic wr_syn;
    logic rd_syn;
    logic clr_v;
    logic clr_of;
    logic clr_ce;
    logic [31:0] feature;
    logic [31:0] syndrome;
    logic [31:0] control;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in,
                   secure: secure_in};
    assign err = '{valid: err_valid_in, tag_err: err_tag_in,
                   source: err_source_in};

    ////////////////////////////////////////////////////////////////////
    // Constant and assembled views
    always_comb begin
        feature = 32'h0000_0000;
        feature[tuerr_pkg::FEAT_IC_LSB +: 2] = tuerr_pkg::FEAT_IC_VAL; // RULE1
        feature[tuerr_pkg::FEAT_DT_LSB +: 2] = tuerr_pkg::FEAT_DT_VAL; // RULE2
        control = 32'h0000_0000;
        control[tuerr_pkg::CTL_IRQ_BIT] = st_r.irq_en;
        syndrome = 32'h0000_0000;
        syndrome[tuerr_pkg::SYN_V_BIT] = st_r.v;
        syndrome[tuerr_pkg::SYN_OVF_BIT] = st_r.ovf;
        syndrome[tuerr_pkg::SYN_CE_LSB +: 2] = st_r.ce;
        syndrome[tuerr_pkg::SYN_SRC_LSB +: 8] = st_r.src; // RULE11
        syndrome[tuerr_pkg::SYN_KIND_LSB +: 8] = st_r.kind;
    end

    // Secure accesses always pass; non-secure ones need the access bit
    assign allowed = bus.secure | nonsecure_reliability_access_in; // RULE4
    assign wr_syn = bus.wr & allowed & (bus.addr == tuerr_pkg::OFF_SYNDROME);
    assign rd_syn = bus.rd & (bus.addr == tuerr_pkg::OFF_IRQ_STATUS);

    // The error-field and valid clears are judged against another flag's clear in the same access
    assign clr_of = wr_syn & bus.wdata[tuerr_pkg::SYN_OVF_BIT]; // RULE8
    assign clr_ce = wr_syn
        & (bus.wdata[tuerr_pkg::SYN_CE_LSB +: 2] == tuerr_pkg::CE_CLEAR_CODE)
        & (!st_r.ovf | clr_of); // RULE10
    assign clr_v = wr_syn & bus.wdata[tuerr_pkg::SYN_V_BIT]
        & ((st_r.ce == tuerr_pkg::CE_NONE) | clr_ce); // RULE6

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (bus.wr && allowed && bus.addr == tuerr_pkg::OFF_CONTROL) begin
            st_nxt.irq_en = bus.wdata[tuerr_pkg::CTL_IRQ_BIT]; // RULE3
        end
        if (bus.wr && bus.addr == tuerr_pkg::OFF_IRQ_MASK) begin
            st_nxt.ev_mask = bus.wdata[1:0];
        end
        // Clears first, so a same-cycle error wins below
        if (clr_v) begin
            st_nxt.v = 1'b0;
        end
        if (clr_of) begin
            st_nxt.ovf = 1'b0;
        end
        if (clr_ce) begin
            st_nxt.ce = tuerr_pkg::CE_NONE;
            st_nxt.kind = tuerr_pkg::KIND_NONE; // RULE14
            st_nxt.src = 8'h00;
        end
        if (rd_syn) begin
            st_nxt.ev_stat = 2'h0;
        end
        if (err.valid) begin
            st_nxt.v = 1'b1; // RULE5
            st_nxt.ev_stat[tuerr_pkg::EV_CE] = 1'b1;
            if (st_nxt.ce != tuerr_pkg::CE_NONE) begin
                st_nxt.ovf = 1'b1; // RULE7
                st_nxt.ev_stat[tuerr_pkg::EV_OVF] = 1'b1;
            end else begin
                st_nxt.ce = tuerr_pkg::CE_CORRECTED; // RULE9
                // Only the first record is kept until acknowledged
                st_nxt.kind = err.tag_err ? tuerr_pkg::KIND_TAG
                                          : tuerr_pkg::KIND_DATA; // RULE13
                st_nxt.src = err.source; // RULE11
            end
        end
        // Source field is never loaded from wdata
        st_nxt.rdata = 32'h0000_0000; // RULE12
        if (bus.rd) begin
            unique case (bus.addr)
                tuerr_pkg::OFF_FEATURE: st_nxt.rdata = allowed ? feature
                                                               : 32'h0;
                tuerr_pkg::OFF_CONTROL: st_nxt.rdata = allowed ? control
                                                               : 32'h0;
                tuerr_pkg::OFF_SYNDROME: st_nxt.rdata = allowed ? syndrome
                                                                : 32'h0;
                tuerr_pkg::OFF_IRQ_STATUS: st_nxt.rdata = {30'h0, st_r.ev_stat};
                tuerr_pkg::OFF_IRQ_MASK: st_nxt.rdata = {30'h0, st_r.ev_mask};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_r <= '{irq_en: tuerr_pkg::RST_CONTROL[tuerr_pkg::CTL_IRQ_BIT],
                      v: 1'b0, ovf: 1'b0, ce: tuerr_pkg::CE_NONE,
                      src: 8'h00, kind: tuerr_pkg::KIND_NONE,
                      ev_stat: 2'h0, ev_mask: tuerr_pkg::RST_IRQ_MASK,
                      rdata: 32'h0000_0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_out = st_r.rdata;
    // Level output, held while enabled until software clears the record
    assign fault_irq_out = st_r.irq_en & st_r.v; // RULE3 RULE15
    assign event_irq_out = |(st_r.ev_stat & st_r.ev_mask);

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_feature_const;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.rd && bus.secure && bus.addr == tuerr_pkg::OFF_FEATURE
            |=> rdata_out[7:0] == 8'h81;
    endproperty
    a_feature_const: assert property (p_feature_const) // RULE1 RULE2
        else $error("feature register value wrong");

    property p_irq_enable;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.wr && allowed && bus.addr == tuerr_pkg::OFF_CONTROL
            && !bus.wdata[tuerr_pkg::CTL_IRQ_BIT] |=> !fault_irq_out;
    endproperty
    a_irq_enable: assert property (p_irq_enable) // RULE3
        else $error("interrupt high after disable");

    property p_ns_raz;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.rd && !bus.secure && !nonsecure_reliability_access_in
            && bus.addr == tuerr_pkg::OFF_SYNDROME |=> rdata_out == 32'h0;
    endproperty
    a_ns_raz: assert property (p_ns_raz) // RULE4
        else $error("non-secure read not zero");

    property p_ns_wi;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.wr && !bus.secure && !nonsecure_reliability_access_in
            && bus.addr == tuerr_pkg::OFF_CONTROL
            |=> $stable(st_r.irq_en);
    endproperty
    a_ns_wi: assert property (p_ns_wi) // RULE4
        else $error("non-secure write took effect");

    property p_v_set;
        @(posedge ref_clk_in) disable iff (rst_in)
        err.valid |=> st_r.v && st_r.ce == tuerr_pkg::CE_CORRECTED;
    endproperty
    a_v_set: assert property (p_v_set) // RULE5 RULE9
        else $error("error not recorded");

    property p_v_guard;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_syn && st_r.v && st_r.ce != 2'h0 && !clr_ce |=> st_r.v;
    endproperty
    a_v_guard: assert property (p_v_guard) // RULE6
        else $error("valid cleared while error field pending");

    property p_of_set;
        @(posedge ref_clk_in) disable iff (rst_in)
        err.valid && st_r.ce != 2'h0 && !clr_ce |=> st_r.ovf;
    endproperty
    a_of_set: assert property (p_of_set) // RULE7
        else $error("overflow not set");

    property p_of_clr;
        @(posedge ref_clk_in) disable iff (rst_in)
        clr_of && !err.valid |=> !st_r.ovf;
    endproperty
    a_of_clr: assert property (p_of_clr) // RULE8
        else $error("overflow not cleared");

    property p_ce_guard;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_syn && st_r.ovf && !clr_of && st_r.ce != 2'h0
            |=> st_r.ce != 2'h0;
    endproperty
    a_ce_guard: assert property (p_ce_guard) // RULE10
        else $error("error field cleared under overflow");

    property p_first_kept;
        @(posedge ref_clk_in) disable iff (rst_in)
        err.valid && st_r.ce != 2'h0 && !clr_ce |=> $stable(st_r.kind)
            && $stable(st_r.src);
    endproperty
    a_first_kept: assert property (p_first_kept) // RULE11 RULE12 RULE13
        else $error("first record overwritten");

    property p_kind_none;
        @(posedge ref_clk_in) disable iff (rst_in)
        st_r.ce == 2'h0 |-> st_r.kind == 8'h00;
    endproperty
    a_kind_none: assert property (p_kind_none) // RULE14
        else $error("kind nonzero without error");

    property p_irq_hold;
        @(posedge ref_clk_in) disable iff (rst_in)
        fault_irq_out && !clr_v
            && !(bus.wr && bus.addr == tuerr_pkg::OFF_CONTROL)
            |=> fault_irq_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold) // RULE15
        else $error("interrupt dropped while pending");

    property p_feature_ns_raz;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.rd && !allowed && bus.addr == tuerr_pkg::OFF_FEATURE
            |=> rdata_out == 32'h0;
    endproperty
    a_feature_ns_raz: assert property (p_feature_ns_raz) // RULE1 RULE2
        else $error("non-secure feature read not zero");

    property p_control_ns_raz;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.rd && !allowed && bus.addr == tuerr_pkg::OFF_CONTROL
            |=> rdata_out == 32'h0;
    endproperty
    a_control_ns_raz: assert property (p_control_ns_raz) // RULE4
        else $error("non-secure control read not zero");

    property p_syn_ns_wi;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.wr && !allowed && bus.addr == tuerr_pkg::OFF_SYNDROME
            && !err.valid |=> $stable(st_r.v) && $stable(st_r.ovf)
            && $stable(st_r.ce);
    endproperty
    a_syn_ns_wi: assert property (p_syn_ns_wi) // RULE4
        else $error("non-secure syndrome write took effect");

    property p_control_read;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.rd && allowed && bus.addr == tuerr_pkg::OFF_CONTROL
            |=> rdata_out == {28'h0, $past(st_r.irq_en), 3'h0};
    endproperty
    a_control_read: assert property (p_control_read) // RULE3
        else $error("control read wrong");

    property p_irq_on;
        @(posedge ref_clk_in) disable iff (rst_in)
        bus.wr && allowed && bus.addr == tuerr_pkg::OFF_CONTROL
            && bus.wdata[tuerr_pkg::CTL_IRQ_BIT] && st_r.v
            |=> fault_irq_out;
    endproperty
    a_irq_on: assert property (p_irq_on) // RULE3
        else $error("enabled interrupt not raised");

    property p_err_irq;
        @(posedge ref_clk_in) disable iff (rst_in)
        err.valid && st_r.irq_en
            && !(bus.wr && bus.addr == tuerr_pkg::OFF_CONTROL)
            |=> fault_irq_out;
    endproperty
    a_err_irq: assert property (p_err_irq) // RULE3 RULE15
        else $error("error did not raise interrupt");

    property p_v_clear;
        @(posedge ref_clk_in) disable iff (rst_in)
        clr_v && !err.valid |=> !st_r.v;
    endproperty
    a_v_clear: assert property (p_v_clear) // RULE6
        else $error("valid not cleared");

    property p_v_keep;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_syn && !bus.wdata[tuerr_pkg::SYN_V_BIT] && st_r.v |=> st_r.v;
    endproperty
    a_v_keep: assert property (p_v_keep) // RULE6
        else $error("valid cleared by a zero write");

    property p_ovf_keep;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_syn && !bus.wdata[tuerr_pkg::SYN_OVF_BIT] && st_r.ovf |=> st_r.ovf;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) // RULE8
        else $error("overflow cleared by a zero write");

    property p_ce_clear;
        @(posedge ref_clk_in) disable iff (rst_in)
        clr_ce && !err.valid |=> st_r.ce == tuerr_pkg::CE_NONE;
    endproperty
    a_ce_clear: assert property (p_ce_clear) // RULE10
        else $error("error field not cleared");

    property p_ce_keep;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_syn && st_r.ce != tuerr_pkg::CE_NONE
            && bus.wdata[tuerr_pkg::SYN_CE_LSB +: 2]
               != tuerr_pkg::CE_CLEAR_CODE
            |=> st_r.ce != tuerr_pkg::CE_NONE;
    endproperty
    a_ce_keep: assert property (p_ce_keep) // RULE10
        else $error("error field cleared by other code");

    property p_kind_legal;
        @(posedge ref_clk_in) disable iff (rst_in)
        st_r.ce != tuerr_pkg::CE_NONE |-> st_r.kind == tuerr_pkg::KIND_TAG
            || st_r.kind == tuerr_pkg::KIND_DATA;
    endproperty
    a_kind_legal: assert property (p_kind_legal) // RULE14
        else $error("kind code illegal with error recorded");

    property p_first_load;
        @(posedge ref_clk_in) disable iff (rst_in)
        err.valid && (st_r.ce == tuerr_pkg::CE_NONE || clr_ce)
            |=> st_r.src == $past(err.source)
            && st_r.kind == ($past(err.tag_err) ? tuerr_pkg::KIND_TAG
                                                : tuerr_pkg::KIND_DATA);
    endproperty
    a_first_load: assert property (p_first_load) // RULE11 RULE13 RULE14
        else $error("first record not loaded");

    property p_src_wi;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_syn && !err.valid && !clr_ce |=> $stable(st_r.src);
    endproperty
    a_src_wi: assert property (p_src_wi) // RULE12
        else $error("source field changed by a write");

    property p_irq_clear;
        @(posedge ref_clk_in) disable iff (rst_in)
        clr_v && !err.valid |=> !fault_irq_out;
    endproperty
    a_irq_clear: assert property (p_irq_clear) // RULE15
        else $error("interrupt held after record cleared");

    property p_rdata_idle;
        @(posedge ref_clk_in) disable iff (rst_in)
        !bus.rd |=> rdata_out == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

endmodule : tuerr_record

//--- verification/tb_translation_unit_error_record.sv
// Self-checking bench for the translation unit error record.
// Assumes one 50 MHz clock; the bench drives all ports itself.
`timescale 1ns/100ps

module tb_translation_unit_error_record;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic secure_in = 1'b1;
    logic access_in = 1'b1;
    logic err_valid_in = 1'b0;
    logic err_tag_in = 1'b0;
    logic [7:0] err_source_in = 8'h00;
    logic [31:0] rdata_out;
    logic fault_irq_out;
    logic event_irq_out;
    logic [31:0] rd_val;
    logic [15:0] atab [5] = '{16'h8e80, 16'h8e88, 16'h8e90, 16'h8e90,
                              16'h8e84};
    int fail_count = 0;
    int num_checks = 0;
    int m_irq = 1, m_v = 0, m_ovf = 0, m_ce = 0, m_src = 0, m_kind = 0;
    int m_stat = 0, m_mask = 3, n, k;

    tuerr_record u_tuerr_record (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .secure_in(secure_in), .rdata_out(rdata_out),
        .nonsecure_reliability_access_in(access_in),
        .err_valid_in(err_valid_in), .err_tag_in(err_tag_in),
        .err_source_in(err_source_in), .fault_irq_out(fault_irq_out),
        .event_irq_out(event_irq_out));

    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////
    // Reference model
    function automatic logic [31:0] model_rd(logic [15:0] a, logic g);
        case (a)
            16'h8e80: return g ? 32'h0000_0081 : 32'h0;
            16'h8e88: return g ? {28'h0, m_irq[0], 3'h0} : 32'h0;
            16'h8e90: return g ? {1'b0, m_v[0], 2'h0, m_ovf[0], 1'b0,
                m_ce[1:0], 8'h00, m_src[7:0], m_kind[7:0]} : 32'h0;
            16'h8ea0: return {30'h0, m_stat[1:0]};
            16'h8ea4: return {30'h0, m_mask[1:0]};
            default: return 32'h0;
        endcase
    endfunction : model_rd

    task automatic model_wr(logic [15:0] a, logic [31:0] d, logic g);
        int ce_clr;
        ce_clr = (d[25:24] == 2'h3) && !(m_ovf != 0 && !d[27]);
        if (a == 16'h8ea4) m_mask = d[1:0];
        if (g && a == 16'h8e88) m_irq = d[3];
        if (g && a == 16'h8e90) begin
            if (d[30] && (m_ce == 0 || ce_clr != 0)) m_v = 0;
            if (d[27]) m_ovf = 0;
            if (ce_clr != 0) begin
                m_ce = 0;
                m_src = 0;
                m_kind = 0;
            end
        end
    endtask : model_wr

    // Every error is an event; only the first one fills the record
    task automatic model_err(logic t, logic [7:0] src);
        m_v = 1;
        m_stat = m_stat | 1;
        if (m_ce == 0) begin
            m_ce = 2;
            m_src = src;
            m_kind = t ? 7 : 8;
        end else begin
            m_ovf = 1;
            m_stat = m_stat | 2;
        end
    endtask : model_err

    ////////////////////////////////////////////////////////////////////
    // Checks and drivers
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic op(logic w, logic [15:0] a, logic [31:0] d, logic s,
                      logic acc);
        logic [31:0] e;
        e = model_rd(a, s | acc);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        secure_in <= s;
        access_in <= acc;
        wr_in <= w;
        rd_in <= !w;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        rd_val = rdata_out;
        if (w) model_wr(a, d, s | acc);
        else chk(rdata_out, e);
        if (!w && a == 16'h8ea0) m_stat = 0;
        chk({31'h0, fault_irq_out}, {31'h0, 1'(m_irq & m_v)});
    endtask : op

    task automatic inj(logic t, logic [7:0] src);
        @(posedge ref_clk_in);
        err_valid_in <= 1'b1;
        err_tag_in <= t;
        err_source_in <= src;
        @(posedge ref_clk_in);
        err_valid_in <= 1'b0;
        #1;
        model_err(t, src);
        chk({31'h0, fault_irq_out}, {31'h0, 1'(m_irq & m_v)});
    endtask : inj

    // Secure access and error report in the same cycle: the error wins
    task automatic both(logic w, logic [15:0] a, logic [31:0] d, logic t);
        logic [31:0] e;
        e = model_rd(a, 1'b1);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        secure_in <= 1'b1;
        wr_in <= w;
        rd_in <= !w;
        err_valid_in <= 1'b1;
        err_tag_in <= t;
        err_source_in <= 8'h04;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        err_valid_in <= 1'b0;
        #1;
        if (w) model_wr(a, d, 1'b1);
        else chk(rdata_out, e);
        if (!w && a == 16'h8ea0) m_stat = 0;
        model_err(t, 8'h04);
        chk({31'h0, fault_irq_out}, {31'h0, 1'(m_irq & m_v)});
    endtask : both

    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Whole run is a few hundred cycles; this bound is generous
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fail_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        n = $urandom(11);
        foreach (atab[i]) op(1'b0, atab[i], 32'h0, 1'b1, 1'b1);
        op(1'b1, 16'h8ea4, 32'h0, 1'b1, 1'b1);
        inj(1'b1, 8'h03);
        chk({31'h0, event_irq_out}, 32'h0);
        op(1'b0, 16'h8e90, 32'h0, 1'b1, 1'b1);
        chk(rd_val, 32'h4200_0307);
        op(1'b1, 16'h8ea4, 32'h1, 1'b1, 1'b1);
        chk({31'h0, event_irq_out}, 32'h1);
        op(1'b0, 16'h8ea0, 32'h0, 1'b1, 1'b1);
        chk({31'h0, event_irq_out}, 32'h0);
        inj(1'b0, 8'h05);
        op(1'b1, 16'h8e90, 32'h4000_0000, 1'b1, 1'b1);
        op(1'b1, 16'h8e90, 32'h0300_0000, 1'b1, 1'b1);
        op(1'b0, 16'h8e90, 32'h0, 1'b1, 1'b1);
        chk(rd_val, 32'h4a00_0307);
        op(1'b1, 16'h8e90, 32'h0800_0000, 1'b1, 1'b1);
        op(1'b1, 16'h8e90, 32'h4300_ff00, 1'b1, 1'b1);
        op(1'b0, 16'h8e90, 32'h0, 1'b1, 1'b1);
        op(1'b1, 16'h8e88, 32'h0, 1'b1, 1'b1);
        inj(1'b0, 8'h08);
        op(1'b1, 16'h8e88, 32'h8, 1'b1, 1'b1);
        op(1'b1, 16'h8e88, 32'h0, 1'b0, 1'b0);
        op(1'b1, 16'h8e90, 32'h4b00_0000, 1'b0, 1'b0);
        op(1'b0, 16'h8e90, 32'h0, 1'b0, 1'b0);
        op(1'b0, 16'h8e88, 32'h0, 1'b0, 1'b1);
        both(1'b0, 16'h8ea0, 32'h0, 1'b1);
        op(1'b0, 16'h8ea0, 32'h0, 1'b1, 1'b1);
        both(1'b1, 16'h8e90, 32'h4b00_0000, 1'b0);
        op(1'b0, 16'h8e90, 32'h0, 1'b1, 1'b1);
        chk(rd_val, 32'h4200_0408);
        // Random mix of errors, reads and guarded writes against the model
        for (n = 0; n < 80; n++) begin
            k = $urandom_range(0, 3);
            if (k == 0) inj(1'($urandom_range(0, 1)),
                            8'($urandom_range(0, 8)));
            else op(k == 1, atab[$urandom_range(0, 4)], $urandom(),
                    1'($urandom_range(0, 1)),
                    $urandom_range(0, 3) != 0);
        end
        results();
    end
endmodule : tb_translation_unit_error_record
